// ==== hw/pmx_pad_drive.sv ====
// Driver control for one port pin from its mode and output value
`timescale 1ns/100ps
module pmx_pad_drive
  import pmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pmx_mode_t mode,
  input wire logic data_out,
  output pmx_pad_t pad
);

  logic prev_ff;
  logic nxt_prev;
  pmx_pad_t pad_ff;
  pmx_pad_t nxt_pad;

  // ****************************************
  // Mode to driver decode
  // ****************************************
  always_comb begin
    nxt_prev = data_out;
    nxt_pad = '0;
    case (mode)
      // (R11) one cycle high pulse
      PMX_MODE_QUASI: begin
        nxt_pad.low_drv = ~data_out;
        nxt_pad.pullup_en = data_out;
        nxt_pad.high_drv = data_out & ~prev_ff;
      end
      // (R12) input only drivers
      PMX_MODE_INPUT: begin
        nxt_pad.pullup_en = 1'b1;
        nxt_prev = 1'b1;
      end
      // (R14) open drain, no pulse
      PMX_MODE_OPEN_DRAIN: begin
        nxt_pad.low_drv = ~data_out;
        nxt_pad.pullup_en = data_out;
      end
      // (R15) push pull drive
      PMX_MODE_PUSH_PULL: begin
        nxt_pad.low_drv = ~data_out;
        nxt_pad.high_drv = data_out;
      end
      // (R13) analog all drivers off
      PMX_MODE_ANALOG: begin
        nxt_pad.analog_en = 1'b1;
        nxt_prev = 1'b1;
      end
      default: begin
        nxt_pad.pullup_en = 1'b1;
        nxt_prev = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= PMX_PREV_RESET;
      pad_ff <= '{analog_en: 1'b0, pullup_en: 1'b1, high_drv: 1'b0, low_drv: 1'b0};
    end else begin
      prev_ff <= nxt_prev;
      pad_ff <= nxt_pad;
    end
  end

  assign pad = pad_ff;

endmodule

// ==== hw/pmx_pkg.sv ====
// Constants, types and structs for the port alternate-function multiplexer
package pmx_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam int unsigned PMX_ADDR_W = 12;
  localparam logic [7:0] PMX_IDX_P1_LOW = 8'h8E;
  localparam logic [7:0] PMX_IDX_P1_HIGH = 8'h8F;
  localparam logic [7:0] PMX_IDX_P3 = 8'h91;
  localparam logic [7:0] PMX_IDX_P4_LOW = 8'h92;
  localparam logic [7:0] PMX_IDX_P4_HIGH = 8'h93;
  localparam logic [7:0] PMX_IDX_PIN_STATE = 8'h94;
  localparam logic [11:0] PMX_ADDR_P1_LOW = {2'h0, PMX_IDX_P1_LOW, 2'h0};
  localparam logic [11:0] PMX_ADDR_P1_HIGH = {2'h0, PMX_IDX_P1_HIGH, 2'h0};
  localparam logic [11:0] PMX_ADDR_P3 = {2'h0, PMX_IDX_P3, 2'h0};
  localparam logic [11:0] PMX_ADDR_P4_LOW = {2'h0, PMX_IDX_P4_LOW, 2'h0};
  localparam logic [11:0] PMX_ADDR_P4_HIGH = {2'h0, PMX_IDX_P4_HIGH, 2'h0};
  localparam logic [11:0] PMX_ADDR_PIN_STATE = {2'h0, PMX_IDX_PIN_STATE, 2'h0};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PMX_SEL_RESET = 8'h00;
  localparam logic [7:0] PMX_PIN_RESET = 8'hFF;
  localparam logic PMX_PREV_RESET = 1'b1;

  // ****************************************
  // Pin positions of functions
  // ****************************************
  localparam int unsigned P3_UART_A_RX = 0;
  localparam int unsigned P3_UART_A_TX = 1;
  localparam int unsigned P3_IRQ_A = 2;
  localparam int unsigned P3_IRQ_B = 3;
  localparam int unsigned P3_CNT_A = 4;
  localparam int unsigned P3_CNT_B = 5;
  localparam int unsigned P3_TWI_DATA = 6;
  localparam int unsigned P3_TWI_CLOCK = 7;
  // Digital group shared by port 1 alternate 1 and port 4 alternate 2
  localparam int unsigned DG_T2_COUNT = 0;
  localparam int unsigned DG_T2_TRIG = 1;
  localparam int unsigned DG_UART_B_RX = 2;
  localparam int unsigned DG_UART_B_TX = 3;
  localparam int unsigned DG_SPI_CLOCK = 4;
  localparam int unsigned DG_SPI_RX = 5;
  localparam int unsigned DG_SPI_TX = 6;
  localparam int unsigned DG_SPI_SEL = 7;
  // Capture/compare group on port 4 alternate 1
  localparam int unsigned CC_CLOCK_A = 3;
  localparam int unsigned CC_CLOCK_B = 7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PMX_MODE_QUASI,
    PMX_MODE_INPUT,
    PMX_MODE_OPEN_DRAIN,
    PMX_MODE_PUSH_PULL,
    PMX_MODE_ANALOG
  } pmx_mode_t;

  typedef enum logic [1:0] {
    PMX_ROUTE_GPIO,
    PMX_ROUTE_ALT1,
    PMX_ROUTE_ALT2
  } pmx_route_t;

  typedef struct packed {
    logic analog_en;
    logic pullup_en;
    logic high_drv;
    logic low_drv;
  } pmx_pad_t;

  typedef struct packed {
    logic uart_a_transmit;
    logic uart_b_transmit;
    logic serial_periph_clock;
    logic serial_periph_transmit;
    logic serial_periph_select_n;
    logic twowire_data_low;
    logic twowire_clock_low;
    logic [5:0] capcom_out;
    logic [5:0] capcom_oe;
  } pmx_periph_out_t;

  typedef struct packed {
    logic uart_a_receive;
    logic uart_b_receive;
    logic external_irq_a;
    logic external_irq_b;
    logic counter_a_input;
    logic counter_b_input;
    logic twowire_data_pin;
    logic twowire_clock_pin;
    logic timer_two_count_in;
    logic timer_two_trigger_in;
    logic serial_periph_receive;
    logic [5:0] capcom_in;
    logic capcom_ext_clock_a;
    logic capcom_ext_clock_b;
  } pmx_periph_in_t;

endpackage

// ==== hw/pmx_port_mux.sv ====
// Alternate-function pin multiplexer for three ports with APB select registers
`timescale 1ns/100ps

// Functional notes
// (R1) Reset clears all five selects to GPIO
// (R2) Each pin selects its function independently
// (R3) Port 3 bits 0-5 route UART, irq, counters
// (R4) Port 3 bits 6, 7 route two-wire bus
// (R5) Port 1 low select zero means GPIO
// (R6) Port 1 alternate 1: timer two, UART, SPI
// (R7) Port 1 both bits: analog channel i
// (R8) Port 4 alternate 1: capture/compare pins
// (R9) Port 4 both bits: timer two, UART, SPI
// (R10) Timer two, UART B on either port
// (R11) UART/SPI pins quasi, one-cycle high pulse
// (R12) Timer and capcom inputs are input only
// (R13) Analog pins: every driver and pull-up off
// (R14) Two-wire pins open drain, port 3 only
// (R15) Capcom outputs push-pull, port 4 only
// (R16) GPIO latch zero pulls low, one pulses
// (R17) Unrouted inputs read one; port 1 wins
module pmx_port_mux
  import pmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port1_latch,
  input wire logic [7:0] port3_latch,
  input wire logic [7:0] port4_latch,
  input wire logic [7:0] port1_pin,
  input wire logic [7:0] port3_pin,
  input wire logic [7:0] port4_pin,
  output logic [7:0] port1_level,
  output logic [7:0] port3_level,
  output logic [7:0] port4_level,
  input wire pmx_periph_out_t periph_out,
  output pmx_periph_in_t periph_in,
  output logic [7:0] analog_channel_enable,
  output pmx_pad_t [7:0] port1_pad,
  output pmx_pad_t [7:0] port3_pad,
  output pmx_pad_t [7:0] port4_pad
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic pmx_route_t route_of(input logic sel_low, input logic sel_high);
    pmx_route_t r;
    r = PMX_ROUTE_GPIO;
    if (sel_low && sel_high) begin
      r = PMX_ROUTE_ALT2;
    end else if (sel_low) begin
      r = PMX_ROUTE_ALT1;
    end
    return r;
  endfunction

  function automatic pmx_mode_t digital_mode(input int unsigned idx);
    pmx_mode_t m;
    m = PMX_MODE_QUASI;
    if (idx == DG_T2_COUNT || idx == DG_T2_TRIG) begin
      m = PMX_MODE_INPUT;
    end
    return m;
  endfunction

  function automatic logic digital_data(input int unsigned idx, input pmx_periph_out_t po);
    logic d;
    d = 1'b1;
    case (idx)
      DG_UART_B_TX: d = po.uart_b_transmit;
      DG_SPI_CLOCK: d = po.serial_periph_clock;
      DG_SPI_TX: d = po.serial_periph_transmit;
      DG_SPI_SEL: d = po.serial_periph_select_n;
      default: d = 1'b1;
    endcase
    return d;
  endfunction

  function automatic logic pick(input logic sel_a, input logic val_a, input logic sel_b,
                                input logic val_b);
    logic v;
    v = 1'b1;
    if (sel_a) begin
      v = val_a;
    end else if (sel_b) begin
      v = val_b;
    end
    return v;
  endfunction

  // ****************************************
  // Select registers and APB slave
  // ****************************************
  logic [7:0] p1_low_ff;
  logic [7:0] p1_high_ff;
  logic [7:0] p3_sel_ff;
  logic [7:0] p4_low_ff;
  logic [7:0] p4_high_ff;
  logic [31:0] prdata_ff;
  logic [7:0] nxt_p1_low;
  logic [7:0] nxt_p1_high;
  logic [7:0] nxt_p3_sel;
  logic [7:0] nxt_p4_low;
  logic [7:0] nxt_p4_high;
  logic [31:0] nxt_prdata;
  logic addr_hit;
  logic wr_en;
  logic [7:0] pin1_sync_ff;
  logic [7:0] pin3_sync_ff;
  logic [7:0] pin4_sync_ff;

  assign wr_en = psel & penable & pwrite;

  always_comb begin
    nxt_p1_low = p1_low_ff;
    nxt_p1_high = p1_high_ff;
    nxt_p3_sel = p3_sel_ff;
    nxt_p4_low = p4_low_ff;
    nxt_p4_high = p4_high_ff;
    nxt_prdata = prdata_ff;
    addr_hit = 1'b1;
    if (paddr == PMX_ADDR_P1_LOW) begin
      if (wr_en) nxt_p1_low = pwdata[7:0];
      nxt_prdata = {24'h000000, p1_low_ff};
    end else if (paddr == PMX_ADDR_P1_HIGH) begin
      if (wr_en) nxt_p1_high = pwdata[7:0];
      nxt_prdata = {24'h000000, p1_high_ff};
    end else if (paddr == PMX_ADDR_P3) begin
      if (wr_en) nxt_p3_sel = pwdata[7:0];
      nxt_prdata = {24'h000000, p3_sel_ff};
    end else if (paddr == PMX_ADDR_P4_LOW) begin
      if (wr_en) nxt_p4_low = pwdata[7:0];
      nxt_prdata = {24'h000000, p4_low_ff};
    end else if (paddr == PMX_ADDR_P4_HIGH) begin
      if (wr_en) nxt_p4_high = pwdata[7:0];
      nxt_prdata = {24'h000000, p4_high_ff};
    end else if (paddr == PMX_ADDR_PIN_STATE) begin
      nxt_prdata = {8'h00, pin4_sync_ff, pin3_sync_ff, pin1_sync_ff};
    end else begin
      addr_hit = 1'b0;
      nxt_prdata = 32'h00000000;
    end
    if (!(psel && !penable)) begin
      nxt_prdata = prdata_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // (R1) selects clear to GPIO
      p1_low_ff <= PMX_SEL_RESET;
      p1_high_ff <= PMX_SEL_RESET;
      p3_sel_ff <= PMX_SEL_RESET;
      p4_low_ff <= PMX_SEL_RESET;
      p4_high_ff <= PMX_SEL_RESET;
      prdata_ff <= 32'h00000000;
    end else begin
      p1_low_ff <= nxt_p1_low;
      p1_high_ff <= nxt_p1_high;
      p3_sel_ff <= nxt_p3_sel;
      p4_low_ff <= nxt_p4_low;
      p4_high_ff <= nxt_p4_high;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  logic [7:0] pin1_meta_ff;
  logic [7:0] pin3_meta_ff;
  logic [7:0] pin4_meta_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_meta_ff <= PMX_PIN_RESET;
      pin3_meta_ff <= PMX_PIN_RESET;
      pin4_meta_ff <= PMX_PIN_RESET;
      pin1_sync_ff <= PMX_PIN_RESET;
      pin3_sync_ff <= PMX_PIN_RESET;
      pin4_sync_ff <= PMX_PIN_RESET;
    end else begin
      pin1_meta_ff <= port1_pin;
      pin3_meta_ff <= port3_pin;
      pin4_meta_ff <= port4_pin;
      pin1_sync_ff <= pin1_meta_ff;
      pin3_sync_ff <= pin3_meta_ff;
      pin4_sync_ff <= pin4_meta_ff;
    end
  end

  assign port1_level = pin1_sync_ff;
  assign port3_level = pin3_sync_ff;
  assign port4_level = pin4_sync_ff;

  // ****************************************
  // Per-pin mode and output value
  // ****************************************
  pmx_mode_t [7:0] mode1;
  pmx_mode_t [7:0] mode3;
  pmx_mode_t [7:0] mode4;
  logic [7:0] data1;
  logic [7:0] data3;
  logic [7:0] data4;
  logic [7:0] p1_dig;
  logic [7:0] p4_dig;
  logic [7:0] p4_cc;
  int unsigned mod_idx;

  always_comb begin
    mod_idx = 0;
    for (int unsigned i = 0; i < 8; i++) begin
      // (R2) each pin decoded alone
      p1_dig[i] = 1'b0;
      p4_dig[i] = 1'b0;
      p4_cc[i] = 1'b0;
      // (R16) GPIO follows latch
      mode1[i] = PMX_MODE_QUASI;
      data1[i] = port1_latch[i];
      mode3[i] = PMX_MODE_QUASI;
      data3[i] = port3_latch[i];
      mode4[i] = PMX_MODE_QUASI;
      data4[i] = port4_latch[i];
      // (R5) low select zero is GPIO
      case (route_of(p1_low_ff[i], p1_high_ff[i]))
        // (R6) digital group on port 1
        PMX_ROUTE_ALT1: begin
          p1_dig[i] = 1'b1;
          mode1[i] = digital_mode(i);
          data1[i] = digital_data(i, periph_out);
        end
        // (R7) analog channel i
        PMX_ROUTE_ALT2: begin
          mode1[i] = PMX_MODE_ANALOG;
          data1[i] = 1'b1;
        end
        default: begin
          mode1[i] = PMX_MODE_QUASI;
        end
      endcase
      // (R3) port 3 peripheral routing
      if (p3_sel_ff[i]) begin
        mode3[i] = PMX_MODE_INPUT;
        data3[i] = 1'b1;
        if (i == P3_UART_A_RX) begin
          mode3[i] = PMX_MODE_QUASI;
        end else if (i == P3_UART_A_TX) begin
          mode3[i] = PMX_MODE_QUASI;
          data3[i] = periph_out.uart_a_transmit;
        end else if (i == P3_TWI_DATA) begin
          // (R4) two-wire data open drain
          mode3[i] = PMX_MODE_OPEN_DRAIN;
          data3[i] = ~periph_out.twowire_data_low;
        end else if (i == P3_TWI_CLOCK) begin
          // (R4) two-wire clock open drain
          mode3[i] = PMX_MODE_OPEN_DRAIN;
          data3[i] = ~periph_out.twowire_clock_low;
        end
      end
      case (route_of(p4_low_ff[i], p4_high_ff[i]))
        // (R8) capture/compare group
        PMX_ROUTE_ALT1: begin
          p4_cc[i] = 1'b1;
          mode4[i] = PMX_MODE_INPUT;
          data4[i] = 1'b1;
          if (i != CC_CLOCK_A && i != CC_CLOCK_B) begin
            mod_idx = (i > CC_CLOCK_A) ? i - 1 : i;
            if (periph_out.capcom_oe[mod_idx]) begin
              mode4[i] = PMX_MODE_PUSH_PULL;
              data4[i] = periph_out.capcom_out[mod_idx];
            end
          end
        end
        // (R9) digital group on port 4
        PMX_ROUTE_ALT2: begin
          p4_dig[i] = 1'b1;
          mode4[i] = digital_mode(i);
          data4[i] = digital_data(i, periph_out);
        end
        default: begin
          mode4[i] = PMX_MODE_QUASI;
        end
      endcase
    end
  end

  // ****************************************
  // Peripheral inputs
  // ****************************************
  pmx_periph_in_t in_ff;
  pmx_periph_in_t nxt_in;
  logic [7:0] p3_in;
  logic [7:0] cc_in;

  always_comb begin
    // (R17) unrouted inputs idle high
    p3_in = pin3_sync_ff | ~p3_sel_ff;
    cc_in = pin4_sync_ff | ~p4_cc;
    nxt_in = '1;
    nxt_in.uart_a_receive = p3_in[P3_UART_A_RX];
    nxt_in.external_irq_a = p3_in[P3_IRQ_A];
    nxt_in.external_irq_b = p3_in[P3_IRQ_B];
    nxt_in.counter_a_input = p3_in[P3_CNT_A];
    nxt_in.counter_b_input = p3_in[P3_CNT_B];
    nxt_in.twowire_data_pin = p3_in[P3_TWI_DATA];
    nxt_in.twowire_clock_pin = p3_in[P3_TWI_CLOCK];
    // (R10) either port; (R17) port 1 wins
    nxt_in.timer_two_count_in = pick(p1_dig[DG_T2_COUNT], pin1_sync_ff[DG_T2_COUNT],
                                     p4_dig[DG_T2_COUNT], pin4_sync_ff[DG_T2_COUNT]);
    nxt_in.timer_two_trigger_in = pick(p1_dig[DG_T2_TRIG], pin1_sync_ff[DG_T2_TRIG],
                                       p4_dig[DG_T2_TRIG], pin4_sync_ff[DG_T2_TRIG]);
    nxt_in.uart_b_receive = pick(p1_dig[DG_UART_B_RX], pin1_sync_ff[DG_UART_B_RX],
                                 p4_dig[DG_UART_B_RX], pin4_sync_ff[DG_UART_B_RX]);
    nxt_in.serial_periph_receive = pick(p1_dig[DG_SPI_RX], pin1_sync_ff[DG_SPI_RX],
                                        p4_dig[DG_SPI_RX], pin4_sync_ff[DG_SPI_RX]);
    // (R12) capcom inputs from port 4
    nxt_in.capcom_ext_clock_a = cc_in[CC_CLOCK_A];
    nxt_in.capcom_ext_clock_b = cc_in[CC_CLOCK_B];
    nxt_in.capcom_in = {cc_in[6:4], cc_in[2:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ff <= '1;
    end else begin
      in_ff <= nxt_in;
    end
  end

  assign periph_in = in_ff;

  // ****************************************
  // Pad drivers
  // ****************************************
  pmx_pad_t [7:0] pad1;

  for (genvar g = 0; g < 8; g++) begin : g_pin
    pmx_pad_drive u_pad1 (.pclk(pclk), .presetn(presetn), .mode(mode1[g]), .data_out(data1[g]),
      .pad(pad1[g]));
    pmx_pad_drive u_pad3 (.pclk(pclk), .presetn(presetn), .mode(mode3[g]), .data_out(data3[g]),
      .pad(port3_pad[g]));
    pmx_pad_drive u_pad4 (.pclk(pclk), .presetn(presetn), .mode(mode4[g]), .data_out(data4[g]),
      .pad(port4_pad[g]));
    // (R13) analog route to converter
    assign analog_channel_enable[g] = pad1[g].analog_en;
  end

  assign port1_pad = pad1;

endmodule

// ==== test/pmx_pin_model.sv ====
// Model of external devices on the pins of the three ports
`timescale 1ns/100ps
module pmx_pin_model
  import pmx_pkg::*;
(
  input wire logic pclk,
  input wire pmx_pad_t [7:0] port1_pad,
  input wire pmx_pad_t [7:0] port3_pad,
  input wire pmx_pad_t [7:0] port4_pad,
  input wire logic [23:0] ext_low,
  output logic [23:0] pin
);
  pmx_pad_t [23:0] pads;
  logic [23:0] last_ff = 24'h000000;
  assign pads = {port4_pad, port3_pad, port1_pad};
  // ****************************************
  // Wire level from every driver on the pin
  // ****************************************
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (ext_low[i] || pads[i].low_drv) begin
        pin[i] = 1'b0;
      end else if (pads[i].high_drv || pads[i].pullup_en) begin
        pin[i] = 1'b1;
      end else begin
        // Undriven pin drifts away from its last level
        pin[i] = ~last_ff[i];
      end
    end
  end
  always @(posedge pclk) begin
    last_ff <= pin;
  end
endmodule

// ==== test/pmx_port_mux_chk.sv ====
// Concurrent checks on the ports of the pin multiplexer
`timescale 1ns/100ps
module pmx_port_mux_chk
  import pmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [7:0] port1_latch,
  input wire pmx_periph_out_t periph_out,
  input wire logic [7:0] analog_channel_enable,
  input wire pmx_pad_t [7:0] port1_pad,
  input wire pmx_pad_t [7:0] port3_pad,
  input wire pmx_pad_t [7:0] port4_pad
);
  // ****************************************
  // Shadow of the five select registers
  // ****************************************
  logic [39:0] sel_ff;
  logic [39:0] nxt_sel;
  always_comb begin
    nxt_sel = sel_ff;
    if (psel && penable && pwrite && pready) begin
      case (paddr)
        PMX_ADDR_P1_LOW: nxt_sel[7:0] = pwdata[7:0];
        PMX_ADDR_P1_HIGH: nxt_sel[15:8] = pwdata[7:0];
        PMX_ADDR_P3: nxt_sel[23:16] = pwdata[7:0];
        PMX_ADDR_P4_LOW: nxt_sel[31:24] = pwdata[7:0];
        PMX_ADDR_P4_HIGH: nxt_sel[39:32] = pwdata[7:0];
        default: nxt_sel = sel_ff;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= 40'h00_0000_0000;
    end else begin
      sel_ff <= nxt_sel;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_one_pulse(hd);
    hd ##1 !hd;
  endsequence
  for (genvar i = 0; i < 8; i++) begin : g_pin
    chk_pulse_once: assert property ((port1_pad[i].high_drv |=> !port1_pad[i].high_drv)
      and (port3_pad[i].high_drv |=> !port3_pad[i].high_drv))
      else $error("high drive held longer than one cycle");
    chk_drv_exclusive: assert property (!(port4_pad[i].high_drv && port4_pad[i].low_drv)
      && !(port1_pad[i].high_drv && port1_pad[i].low_drv))
      else $error("both drivers on at once");
    chk_analog_quiet: assert property (port1_pad[i].analog_en |-> !port1_pad[i].pullup_en
      && !port1_pad[i].high_drv && !port1_pad[i].low_drv)
      else $error("analog pin has a driver on");
    chk_analog_port_one: assert property (!port3_pad[i].analog_en && !port4_pad[i].analog_en)
      else $error("analog mode outside port 1");
    chk_gpio_low: assert property (!sel_ff[i] && !port1_latch[i] |=> port1_pad[i].low_drv
      && !port1_pad[i].pullup_en)
      else $error("gpio zero not driven low");
    chk_gpio_pulse: assert property (!sel_ff[i] && $stable(sel_ff[i]) && $rose(port1_latch[i])
      |=> s_one_pulse(port1_pad[i].high_drv))
      else $error("gpio rise without one cycle pulse");
    chk_analog_route: assert property (sel_ff[i] && sel_ff[8+i] |=> port1_pad[i].analog_en
      && analog_channel_enable[i])
      else $error("analog channel not routed");
    chk_reset_clear: assert property ($rose(presetn) |-> !analog_channel_enable[i]
      && port1_pad[i].pullup_en && !port1_pad[i].low_drv)
      else $error("pad not in gpio state after reset");
  end
  chk_twowire_od: assert property (sel_ff[22] |=> !port3_pad[6].high_drv
    && (port3_pad[6].low_drv == $past(periph_out.twowire_data_low)))
    else $error("two-wire data pin not open drain");
  chk_capcom_pp: assert property (sel_ff[24] && !sel_ff[32] && periph_out.capcom_oe[0]
    |=> port4_pad[0].high_drv == $past(periph_out.capcom_out[0])
    && port4_pad[0].low_drv != $past(periph_out.capcom_out[0]))
    else $error("capture pin not push-pull");
endmodule
bind pmx_port_mux pmx_port_mux_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .port1_latch(port1_latch), .periph_out(periph_out),
  .analog_channel_enable(analog_channel_enable), .port1_pad(port1_pad),
  .port3_pad(port3_pad), .port4_pad(port4_pad));

// ==== test/pmx_port_mux_tb_top.sv ====
// Self-checking testbench for the pin multiplexer
`timescale 1ns/100ps
module pmx_port_mux_tb_top;
  import pmx_pkg::*;
  localparam logic [11:0] ADDRS [5] = '{PMX_ADDR_P1_LOW, PMX_ADDR_P1_HIGH, PMX_ADDR_P3,
    PMX_ADDR_P4_LOW, PMX_ADDR_P4_HIGH};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port1_latch = 8'hFF;
  logic [23:0] pin;
  logic [23:0] ext_low = 24'h000000;
  logic [7:0] port1_level, port3_level, port4_level, analog_channel_enable;
  pmx_periph_out_t periph_out = '0;
  pmx_periph_in_t periph_in;
  pmx_periph_in_t xin;
  pmx_pad_t [7:0] port1_pad, port3_pad, port4_pad;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int samples_checked = 0;
  always #10 pclk = ~pclk;
  pmx_port_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port1_latch(port1_latch), .port3_latch(8'hFF), .port4_latch(8'hFF),
    .port1_pin(pin[7:0]), .port3_pin(pin[15:8]), .port4_pin(pin[23:16]),
    .port1_level(port1_level), .port3_level(port3_level), .port4_level(port4_level),
    .periph_out(periph_out), .periph_in(periph_in),
    .analog_channel_enable(analog_channel_enable), .port1_pad(port1_pad),
    .port3_pad(port3_pad), .port4_pad(port4_pad));
  pmx_pin_model u_pins (.pclk(pclk), .port1_pad(port1_pad), .port3_pad(port3_pad),
    .port4_pad(port4_pad), .ext_low(ext_low), .pin(pin));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    apb(1'b1, addr, {24'hFFFFFF, data});
  endtask
  task automatic rchk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  task automatic in_chk;
    settle;
    check(32'(periph_in), 32'(xin));
  endtask
  task automatic rise_chk(input int p, input int b);
    @(posedge pclk);
    @(negedge pclk);
    check(32'((p == 1) ? port1_pad[b] : port3_pad[b]), 32'h6);
    @(negedge pclk);
    check(32'((p == 1) ? port1_pad[b] : port3_pad[b]), 32'h4);
    @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 5; r++) begin
      rchk(ADDRS[r], 32'h0, 1'b0);
      wr(ADDRS[r], 8'h11 << r);
    end
    for (int r = 0; r < 5; r++) rchk(ADDRS[r], {24'h0, 8'h11 << r}, 1'b0);
    rchk(12'h3FC, 32'h0, 1'b1);
    for (int r = 0; r < 5; r++) wr(ADDRS[r], 8'h00);
    wr(PMX_ADDR_PIN_STATE, 8'h00);
    settle;
    rchk(PMX_ADDR_PIN_STATE, 32'h00FF_FFFF, 1'b0);
    ext_low <= 24'hFFFFFF;
    xin = '1;
    in_chk;
    check({8'h00, port4_level, port3_level, port1_level}, 32'h0);
    wr(PMX_ADDR_P1_HIGH, 8'hFF);
    wr(PMX_ADDR_P3, 8'hFF);
    xin[18:11] = 8'h40;
    in_chk;
    wr(PMX_ADDR_P1_LOW, 8'h0F);
    wr(PMX_ADDR_P1_HIGH, 8'h00);
    xin.timer_two_count_in = 1'b0;
    xin.timer_two_trigger_in = 1'b0;
    xin.uart_b_receive = 1'b0;
    in_chk;
    check(32'(port1_pad[3]), 32'h1);
    ext_low <= 24'hFFFF00;
    wr(PMX_ADDR_P4_LOW, 8'h0F);
    wr(PMX_ADDR_P4_HIGH, 8'h0F);
    xin.timer_two_count_in = 1'b1;
    xin.timer_two_trigger_in = 1'b1;
    xin.uart_b_receive = 1'b1;
    in_chk;
    wr(PMX_ADDR_P1_LOW, 8'h00);
    xin.timer_two_count_in = 1'b0;
    xin.timer_two_trigger_in = 1'b0;
    xin.uart_b_receive = 1'b0;
    in_chk;
    wr(PMX_ADDR_P4_LOW, 8'hFF);
    wr(PMX_ADDR_P4_HIGH, 8'h00);
    xin = '0;
    xin.timer_two_count_in = 1'b1;
    xin.timer_two_trigger_in = 1'b1;
    xin.serial_periph_receive = 1'b1;
    xin.uart_b_receive = 1'b1;
    in_chk;
    check({30'h0, port4_pad[0].high_drv, port4_pad[0].low_drv}, 32'h0);
    periph_out.capcom_oe[0] <= 1'b1;
    periph_out.capcom_out[0] <= 1'b1;
    settle;
    check({30'h0, port4_pad[0].high_drv, port4_pad[0].low_drv}, 32'h2);
    periph_out.capcom_out[0] <= 1'b0;
    settle;
    check({30'h0, port4_pad[0].high_drv, port4_pad[0].low_drv}, 32'h1);
    ext_low <= 24'h000000;
    wr(PMX_ADDR_P1_LOW, 8'h0F);
    wr(PMX_ADDR_P1_HIGH, 8'h03);
    wr(PMX_ADDR_P3, 8'hC3);
    wr(PMX_ADDR_P4_LOW, 8'hF1);
    wr(PMX_ADDR_P4_HIGH, 8'hF0);
    periph_out.twowire_data_low <= 1'b1;
    settle;
    check({24'h0, analog_channel_enable}, 32'h03);
    check(32'(port1_pad[1]), 32'h8);
    check(32'(port3_pad[6]), 32'h1);
    periph_out.twowire_data_low <= 1'b0;
    settle;
    check(32'(port3_pad[6]), 32'h4);
    periph_out.uart_a_transmit <= 1'b1;
    rise_chk(3, 1);
    port1_latch[4] <= 1'b0;
    settle;
    check(32'(port1_pad[4]), 32'h1);
    port1_latch[4] <= 1'b1;
    rise_chk(1, 4);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(PMX_ADDR_P3, 32'h0, 1'b0);
    finish_test;
  end
endmodule
